/* File: charge_cycle_sequencer.sv */
// Charge phase, soft-start, termination and overvoltage sequencing with AXI4-Lite registers
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
// Operation
// - Soft-start begins at forty percent limit
// - Step 50,60,70,80,100 percent after wait
// - Soft-start reruns only after high impedance
// - Fixed-frequency converter clock
// - All five loops active, dominant controls
// - Short-battery current below threshold, then programmed
// - Thermal loop reduces charge current
// - Floor voltage cuts charge; supplement at zero
// - Full fast-charge above system regulation point
// - Programmable regulation voltage, taper while holding
// - Terminate after deglitched low taper current
// - Inhibit termination on thermal or input loop or minimum
// - After termination regulate system, allow supplement
// - Cleared termination-allow bit disables termination
// - New cycle on supply or battery arrival
// - Recharge on listed events when safe
// - Overvoltage stops converter, opens discharge path
// - Overvoltage fault flagged after deglitch
// - Fault clears below recharge or high impedance
module charge_cycle_sequencer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic charge_off_pin,
  input wire logic supply_valid,
  input wire logic battery_present,
  input wire logic bat_below_short,
  input wire logic sys_above_reg,
  input wire logic bat_at_reg,
  input wire logic bat_below_recharge,
  input wire logic bat_above_ovp,
  input wire logic chg_below_term,
  input wire logic supplement_event,
  input wire logic half_charge,
  input wire logic reverse_boost,
  input wire logic [charge_seq_pkg::NUM_LOOPS-1:0] loop_active,
  output logic [6:0] input_limit_pct,
  output logic converter_on,
  output logic sw_clk,
  output logic bat_switch_on,
  output logic bat_switch_linear,
  output logic short_current_sel,
  output logic fast_current_sel,
  output logic sys_regulate,
  output logic supplement_allow,
  output logic detect_start,
  output logic [7:0] vreg_code,
  output logic [7:0] ichg_code,
  output logic ovp_fault
);
  import charge_seq_pkg::*;
  // loop_active: 0 constant current, 1 constant voltage, 2 thermal,
  // 3 floor system voltage, 4 input voltage power loop.
  logic [5:0] ctrl_r;
  logic [7:0] vreg_r, ichg_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  phase_t phase_r, phase_nxt;
  soft_t ss_r, ss_nxt;
  logic [2:0] step_r;
  logic [CNT_W-1:0] ss_cnt_r, term_cnt_r, ovp_cnt_r;
  logic [7:0] sw_cnt_r;
  logic sw_r, ovp_fault_r, ovp_now_r, detect_r;
  logic [6:0] pct_r;
  logic hiz_prev_r, inh_prev_r, rst_prev_r, cd_prev_r, sup_prev_r, bat_prev_r;

  wire wr_fire = aw_got_r && w_got_r && !bvalid_r;
  wire [7:0] wr_addr = awaddr_r;
  wire rd_fire = s_axi_arvalid && arready_r;
  wire hiz = ctrl_r[CTRL_HIZ_BIT] || charge_off_pin;
  wire te = ctrl_r[CTRL_TE_BIT];
  wire wr_ctrl = wr_fire && wr_addr == CTRL_OFS;
  wire wr_vreg = wr_fire && wr_addr == VREG_OFS;
  wire wr_ichg = wr_fire && wr_addr == ICHG_OFS;
  wire wr_ok = wr_ctrl || wr_vreg || wr_ichg;
  wire rd_ok = s_axi_araddr == CTRL_OFS || s_axi_araddr == VREG_OFS ||
               s_axi_araddr == ICHG_OFS || s_axi_araddr == STAT_OFS ||
               s_axi_araddr == SENSE_OFS;
  wire [31:0] stat_word = {16'h0000, pct_r, step_r, ss_r == SS_DONE,
                           ovp_fault_r, phase_r, ovp_now_r};
  wire [31:0] sense_word = {19'h00000, loop_active, supplement_event,
                            chg_below_term, bat_above_ovp, bat_below_recharge,
                            bat_at_reg, sys_above_reg, bat_below_short, supply_valid};
  wire [31:0] rd_word = s_axi_araddr == CTRL_OFS ? {26'h0, ctrl_r} :
                        s_axi_araddr == VREG_OFS ? {24'h0, vreg_r} :
                        s_axi_araddr == ICHG_OFS ? {24'h0, ichg_r} :
                        s_axi_araddr == STAT_OFS ? stat_word :
                        s_axi_araddr == SENSE_OFS ? sense_word : 32'h0;

  // Overvoltage acts at once, the status flag only after the deglitch
  wire ovp_dgl_done = ovp_cnt_r >= CNT_W'(OVP_DGL_CYC - 1);
  // The thermal or input voltage power loop pulling current down, or the minimum input limit, blocks termination
  wire term_inhibit = ctrl_r[CTRL_MINLIM_BIT] || half_charge || reverse_boost ||
                      ctrl_r[CTRL_LOW_BIT] || loop_active[2] || loop_active[4] ||
                      pct_r != PCT_FULL;
  wire term_qual = phase_r == PH_TAPER && te && !bat_below_recharge &&
                   chg_below_term && !term_inhibit && !supplement_event;
  wire term_done = term_qual && term_cnt_r >= CNT_W'(TERM_DGL_CYC - 1);
  wire new_cycle = !charge_off_pin && supply_valid && battery_present &&
                   bat_below_recharge && ((!sup_prev_r) || (!bat_prev_r));
  wire recharge_evt = supply_valid && !bat_above_ovp && (
                      bat_below_recharge ||
                      (ctrl_r[CTRL_INH_BIT] != inh_prev_r) ||
                      (ctrl_r[CTRL_RST_BIT] != rst_prev_r) ||
                      supplement_event ||
                      (charge_off_pin != cd_prev_r) ||
                      (ctrl_r[CTRL_HIZ_BIT] != hiz_prev_r));
  wire charge_ok = supply_valid && !hiz && !ctrl_r[CTRL_INH_BIT] && battery_present;

  always_comb begin
    phase_nxt = phase_r;
    if (!charge_ok || bat_above_ovp) begin
      phase_nxt = PH_IDLE;
    end else begin
      unique case (phase_r)
        PH_IDLE, PH_DONE: begin
          if (new_cycle || recharge_evt && phase_r == PH_DONE || phase_r == PH_IDLE)
            phase_nxt = bat_below_short ? PH_SHORT : PH_LINEAR;
        end
        PH_SHORT: if (!bat_below_short) phase_nxt = PH_LINEAR;
        PH_LINEAR: if (sys_above_reg) phase_nxt = PH_FAST;
        PH_FAST: if (bat_at_reg) phase_nxt = PH_TAPER;
        PH_TAPER: if (term_done) phase_nxt = PH_DONE;
        default: phase_nxt = PH_IDLE;
      endcase
    end
  end

  always_comb begin
    ss_nxt = ss_r;
    unique case (ss_r)
      SS_HIZ: if (!hiz && supply_valid) ss_nxt = SS_WAIT;
      SS_WAIT: if (ss_cnt_r >= CNT_W'(SOFT_WAIT_CYC - 1)) ss_nxt = SS_STEP;
      SS_STEP: if (ss_cnt_r >= CNT_W'(SOFT_STEP_CYC - 1) && step_r == 3'h4)
        ss_nxt = SS_DONE;
      SS_DONE: ss_nxt = SS_DONE;
      default: ss_nxt = SS_HIZ;
    endcase
    if (hiz) ss_nxt = SS_HIZ;
  end

  wire [6:0] pct_nxt = ss_r == SS_HIZ || ss_r == SS_WAIT ? PCT_START :
                       ss_r == SS_DONE ? PCT_FULL :
                       step_r == 3'h0 ? PCT_50 : step_r == 3'h1 ? PCT_60 :
                       step_r == 3'h2 ? PCT_70 : step_r == 3'h3 ? PCT_80 :
                       PCT_FULL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_r <= SS_HIZ;
      ss_cnt_r <= '0;
      step_r <= 3'h0;
      pct_r <= PCT_START;
    end else if (clk_en) begin
      ss_r <= ss_nxt;
      pct_r <= pct_nxt;
      if (ss_nxt != ss_r || ss_r == SS_STEP && ss_cnt_r >= CNT_W'(SOFT_STEP_CYC - 1))
        ss_cnt_r <= '0;
      else
        ss_cnt_r <= ss_cnt_r + 1'b1;
      if (ss_r != SS_STEP)
        step_r <= 3'h0;
      else if (ss_cnt_r >= CNT_W'(SOFT_STEP_CYC - 1) && step_r != 3'h4)
        step_r <= step_r + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= PH_IDLE;
      term_cnt_r <= '0;
      ovp_cnt_r <= '0;
      ovp_fault_r <= 1'b0;
      ovp_now_r <= 1'b0;
      detect_r <= 1'b0;
      hiz_prev_r <= 1'b0;
      inh_prev_r <= 1'b0;
      rst_prev_r <= 1'b0;
      cd_prev_r <= 1'b0;
      sup_prev_r <= 1'b0;
      bat_prev_r <= 1'b0;
    end else if (clk_en) begin
      phase_r <= phase_nxt;
      term_cnt_r <= term_qual ? term_cnt_r + 1'b1 : '0;
      ovp_cnt_r <= bat_above_ovp && !ovp_dgl_done ? ovp_cnt_r + 1'b1 :
                   bat_above_ovp ? ovp_cnt_r : '0;
      ovp_now_r <= bat_above_ovp;
      // A fresh detection wins over a clear in the same cycle
      if (bat_above_ovp && ovp_dgl_done)
        ovp_fault_r <= 1'b1;
      else if (bat_below_recharge || hiz)
        ovp_fault_r <= 1'b0;
      detect_r <= phase_r == PH_TAPER && phase_nxt == PH_DONE && te;
      hiz_prev_r <= ctrl_r[CTRL_HIZ_BIT];
      inh_prev_r <= ctrl_r[CTRL_INH_BIT];
      rst_prev_r <= ctrl_r[CTRL_RST_BIT];
      cd_prev_r <= charge_off_pin;
      sup_prev_r <= supply_valid;
      bat_prev_r <= battery_present;
    end
  end

  wire converter_ok = supply_valid && !hiz && !bat_above_ovp;

  // Converter timebase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_cnt_r <= 8'h00;
      sw_r <= 1'b0;
    end else if (clk_en) begin
      if (sw_cnt_r >= 8'(SW_DIV_CYC - 1)) begin
        sw_cnt_r <= 8'h00;
      end else begin
        sw_cnt_r <= sw_cnt_r + 8'h01;
      end
      sw_r <= sw_cnt_r < 8'(SW_DIV_CYC / 2) && converter_ok;
    end
  end

  // Output drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_on <= 1'b0;
      bat_switch_on <= 1'b0;
      bat_switch_linear <= 1'b0;
      short_current_sel <= 1'b0;
      fast_current_sel <= 1'b0;
      sys_regulate <= 1'b0;
      supplement_allow <= 1'b0;
    end else if (clk_en) begin
      converter_on <= converter_ok;
      // Charge switch is off after termination but the discharge path opens on overvoltage
      bat_switch_on <= bat_above_ovp || phase_nxt == PH_FAST ||
                       phase_nxt == PH_TAPER;
      bat_switch_linear <= !bat_above_ovp && (phase_nxt == PH_SHORT ||
                           phase_nxt == PH_LINEAR);
      short_current_sel <= phase_nxt == PH_SHORT;
      fast_current_sel <= phase_nxt == PH_LINEAR || phase_nxt == PH_FAST ||
                          phase_nxt == PH_TAPER;
      sys_regulate <= converter_ok && phase_nxt != PH_FAST &&
                      phase_nxt != PH_TAPER;
      // Supplement is blocked only on overvoltage; loops below settle it in the analog domain
      supplement_allow <= !bat_above_ovp;
    end
  end

  // AXI4-Lite slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
      ctrl_r <= CTRL_RESET;
      vreg_r <= VREG_RESET;
      ichg_r <= ICHG_RESET;
    end else if (clk_en) begin
      if (s_axi_awvalid && awready_r) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctrl && wstrb_r[0]) ctrl_r <= wdata_r[5:0];
        if (wr_vreg && wstrb_r[0]) vreg_r <= wdata_r[7:0];
        if (wr_ichg && wstrb_r[0]) ichg_r <= wdata_r[7:0];
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
      if (rd_fire) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign input_limit_pct = pct_r;
  assign sw_clk = sw_r;
  assign detect_start = detect_r;
  assign vreg_code = vreg_r;
  assign ichg_code = ichg_r;
  assign ovp_fault = ovp_fault_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_soft_start_pct: assert property (clk_en && ss_r == SS_WAIT |=> pct_r == PCT_START)
    else $error("limit not at start level during wait");
  a_soft_step_up: assert property (clk_en && ss_r == SS_STEP && step_r == 3'h0 |=>
      pct_r == PCT_50)
    else $error("first step not fifty percent");
  a_soft_no_rerun: assert property (ss_r == SS_DONE && !hiz |=> ss_r == SS_DONE)
    else $error("soft-start left done without high impedance");
  a_ovp_stops_conv: assert property (clk_en && bat_above_ovp |=> !converter_on && bat_switch_on)
    else $error("overvoltage did not stop converter");
  a_ovp_flag_wait: assert property ($rose(ovp_fault_r) |-> $past(ovp_dgl_done))
    else $error("fault flagged before deglitch");
  a_ovp_clear: assert property (clk_en && ovp_fault_r && hiz && !bat_above_ovp |=>
      !ovp_fault_r)
    else $error("fault not cleared in high impedance");
  a_term_disabled: assert property (clk_en && !te |=> !detect_r)
    else $error("terminated with termination disabled");
  a_term_dgl: assert property (phase_r == PH_TAPER && phase_nxt == PH_DONE |->
      term_cnt_r == CNT_W'(TERM_DGL_CYC - 1))
    else $error("terminated without full deglitch");
  a_short_cur: assert property (clk_en && charge_ok && !bat_above_ovp &&
      phase_r == PH_SHORT && bat_below_short |=> short_current_sel)
    else $error("short current not applied");
  c_soft_done: cover property (ss_r == SS_STEP ##1 ss_r == SS_DONE);
  c_term: cover property (detect_r);
  c_ovp: cover property ($rose(ovp_fault_r));
  c_write: cover property (bvalid_r && s_axi_bready);
endmodule : charge_cycle_sequencer
`default_nettype wire

/* File: charge_seq_pkg.sv */
// Constants and types shared by the charge cycle sequencer
`default_nettype none
package charge_seq_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SOFT_WAIT_MS = 80;
  localparam int unsigned SOFT_STEP_US = 256;
  localparam int unsigned TERM_DGL_MS = 32;
  localparam int unsigned OVP_DGL_MS = 1;
  localparam int unsigned SOFT_WAIT_CYC = SOFT_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned SOFT_STEP_CYC = SOFT_STEP_US * (CLK_HZ / 1000000);
  localparam int unsigned TERM_DGL_CYC = TERM_DGL_MS * (CLK_HZ / 1000);
  localparam int unsigned OVP_DGL_CYC = OVP_DGL_MS * (CLK_HZ / 1000);
  localparam int unsigned SW_FREQ_HZ = 1500000;
  // Rounded down so the switching rate never falls below the target
  localparam int unsigned SW_DIV_CYC = CLK_HZ / SW_FREQ_HZ;
  localparam int CNT_W = 32;
  // Input limit percentages, in order of the soft-start schedule
  localparam logic [6:0] PCT_START = 7'h28;
  localparam logic [6:0] PCT_50 = 7'h32;
  localparam logic [6:0] PCT_60 = 7'h3c;
  localparam logic [6:0] PCT_70 = 7'h46;
  localparam logic [6:0] PCT_80 = 7'h50;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam int NUM_LOOPS = 5;
  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] VREG_OFS = 8'h04;
  localparam logic [7:0] ICHG_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] SENSE_OFS = 8'h10;
  localparam int CTRL_TE_BIT = 0;
  localparam int CTRL_HIZ_BIT = 1;
  localparam int CTRL_INH_BIT = 2;
  localparam int CTRL_RST_BIT = 3;
  localparam int CTRL_LOW_BIT = 4;
  localparam int CTRL_MINLIM_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h01;
  localparam logic [7:0] VREG_RESET = 8'h0a;
  localparam logic [7:0] ICHG_RESET = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    PH_IDLE, PH_SHORT, PH_LINEAR, PH_FAST, PH_TAPER, PH_DONE
  } phase_t;
  typedef enum logic [2:0] {
    SS_HIZ, SS_WAIT, SS_STEP, SS_DONE
  } soft_t;
endpackage : charge_seq_pkg
`default_nettype wire

/* File: battery_pack_model.sv */
// Battery pack model: cell voltage and the comparator levels that the sequencer sees
`default_nettype none
module battery_pack_model #(
  parameter int BASE_MV = 3500,
  parameter int LSB_MV = 20,
  parameter int RCH_MV = 100,
  parameter int SHORT_MV = 2000,
  parameter int SLOW = 4096
) (
  input wire logic aclk,
  input wire logic load,
  input wire logic [12:0] load_mv,
  input wire logic converter_on,
  input wire logic bat_switch_on,
  input wire logic [7:0] vreg_code,
  output logic bat_below_short,
  output logic bat_at_reg,
  output logic bat_below_recharge,
  output logic bat_above_ovp
);
  timeunit 1ns;
  timeprecision 100ps;
  int cell_r = 0;
  int div_r = 0;
  int reg_mv;
  assign reg_mv = BASE_MV + LSB_MV * int'(vreg_code);
  always_ff @(posedge aclk) begin
    div_r <= (div_r + 1) % SLOW;
    if (load) begin
      cell_r <= int'(load_mv);
    end else if (bat_switch_on && !converter_on && div_r == 0) begin
      // Drains slowly, one step every SLOW cycles, about ten over an overvoltage deglitch interval
      cell_r <= cell_r - 1;
    end
  end
  assign bat_below_short = cell_r < SHORT_MV;
  assign bat_at_reg = cell_r >= reg_mv;
  assign bat_below_recharge = cell_r < reg_mv - RCH_MV;
  assign bat_above_ovp = cell_r * 100 > reg_mv * 105;
endmodule : battery_pack_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the charge cycle sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import charge_seq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic charge_off_pin = 1'b0, supply_valid = 1'b0, battery_present = 1'b0;
  logic sys_above_reg = 1'b0, chg_below_term = 1'b0;
  logic [NUM_LOOPS-1:0] loop_active = '0;
  logic bat_below_short, bat_at_reg, bat_below_recharge, bat_above_ovp;
  logic [6:0] input_limit_pct;
  logic converter_on, sw_clk, bat_switch_on, ovp_fault;
  logic bat_switch_linear, short_current_sel, fast_current_sel, sys_regulate, supplement_allow;
  logic clk_en = 1'b1;
  wire [5:0] path_vec = {short_current_sel, fast_current_sel, bat_switch_linear, bat_switch_on,
                         sys_regulate, supplement_allow};
  logic [7:0] vreg_code, ichg_code;
  logic load = 1'b0;
  logic [12:0] load_mv = 13'h0;
  logic [31:0] seed = 32'h6ff50f43;
  logic [1:0] exp_b[$];
  logic [65:0] exp_r[$];
  logic [1:0] eb;
  logic [65:0] er;
  logic prev;
  int err_total = 0, n_compared = 0, cyc = 0, k, t0;

  always #12.5 aclk = ~aclk;

  charge_cycle_sequencer dut (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .charge_off_pin,
    .supply_valid, .battery_present, .bat_below_short, .sys_above_reg, .bat_at_reg,
    .bat_below_recharge, .bat_above_ovp, .chg_below_term, .supplement_event(1'b0),
    .half_charge(1'b0), .reverse_boost(1'b0), .loop_active, .input_limit_pct,
    .converter_on, .sw_clk, .bat_switch_on, .bat_switch_linear, .short_current_sel,
    .fast_current_sel, .sys_regulate, .supplement_allow, .detect_start(),
    .vreg_code, .ichg_code, .ovp_fault
  );

  battery_pack_model pack (
    .aclk, .load, .load_mv, .converter_on, .bat_switch_on, .vreg_code,
    .bat_below_short, .bat_at_reg, .bat_below_recharge, .bat_above_ovp
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      err_total++;
    end
  endtask : cmp

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Address and data are released separately, each at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    @(posedge aclk);
    exp_b.push_back(r);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    @(posedge aclk);
    exp_r.push_back({m, d & m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic set_cell(input logic [12:0] mv);
    @(posedge aclk);
    load <= 1'b1;
    load_mv <= mv;
    @(posedge aclk);
    load <= 1'b0;
  endtask : set_cell

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      eb = exp_b.pop_front();
      cmp(32'(s_axi_bresp), 32'(eb), "write response");
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = exp_r.pop_front();
      cmp(s_axi_rdata & er[65:34], er[33:2], "read data");
      cmp(32'(s_axi_rresp), 32'(er[1:0]), "read response");
    end
  end

  // Ceiling sits above the roughly 87k cycles that the sequence needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 97000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    set_cell(13'd1500);
    supply_valid <= 1'b1;
    battery_present <= 1'b1;
    cmp(32'(input_limit_pct), 32'(PCT_START), "limit after reset");
    rd(CTRL_OFS, 32'(CTRL_RESET), 32'h3f, RESP_OKAY);
    cmp(32'(path_vec), 32'h2b, "short battery outputs");
    set_cell(13'd3650);
    rd(VREG_OFS, 32'(VREG_RESET), 32'hff, RESP_OKAY);
    cmp(32'(path_vec), 32'h1b, "linear charge outputs");
    sys_above_reg <= 1'b1;
    rd(ICHG_OFS, 32'(ICHG_RESET), 32'hff, RESP_OKAY);
    cmp(32'(path_vec), 32'h15, "fast charge outputs");
    rd(8'h14, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h14, 32'h5a, RESP_SLVERR);
    wr(CTRL_OFS, 32'h3, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      loop_active <= seed[20:16];
      sys_above_reg <= seed[21];
      chg_below_term <= seed[22];
      wr(VREG_OFS, {24'h0, seed[7:0]}, RESP_OKAY);
      wr(ICHG_OFS, {24'h0, seed[15:8]}, RESP_OKAY);
      rd(VREG_OFS, {24'h0, seed[7:0]}, 32'hff, RESP_OKAY);
      cmp(32'(vreg_code), {24'h0, seed[7:0]}, "vreg code");
      cmp(32'(ichg_code), {24'h0, seed[15:8]}, "ichg code");
    end
    wr(VREG_OFS, 32'(VREG_RESET), RESP_OKAY);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    rd(CTRL_OFS, 32'h0, 32'h3f, RESP_OKAY);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp(32'(input_limit_pct), 32'(PCT_START), "limit leaving high impedance");
    repeat (2000) @(posedge aclk);
    cmp(32'(input_limit_pct), 32'(PCT_START), "limit during wait");
    rd(STAT_OFS, 32'(PCT_START) << 9, 32'hfe20, RESP_OKAY);
    for (int i = 0; i < 200 && !converter_on; i++) @(posedge aclk);
    clk_en <= 1'b0;
    @(posedge aclk);
    prev = sw_clk;
    k = 0;
    repeat (30) begin
      @(posedge aclk);
      if (sw_clk !== prev) k++;
    end
    cmp(32'(k), 32'h0, "outputs frozen by clock enable");
    clk_en <= 1'b1;
    k = 0;
    t0 = 0;
    prev = sw_clk;
    for (int i = 0; i < 100 && k < 2; i++) begin
      @(posedge aclk);
      if (sw_clk && !prev) begin
        k++;
        if (k == 2) cmp(32'(i - t0), 32'd26, "switching period");
        t0 = i;
      end
      prev = sw_clk;
    end
    cmp(32'(k), 32'd2, "switching clock runs");
    set_cell(13'd3950);
    repeat (3) @(posedge aclk);
    cmp(32'(converter_on), 32'h0, "converter off on overvoltage");
    cmp(32'(bat_switch_on), 32'h1, "discharge switch on");
    repeat (5000) @(posedge aclk);
    set_cell(13'd3800);
    repeat (5) @(posedge aclk);
    set_cell(13'd3950);
    repeat (39990) @(posedge aclk);
    cmp(32'(ovp_fault), 32'h0, "fault before deglitch");
    for (int i = 0; i < 30 && !ovp_fault; i++) @(posedge aclk);
    cmp(32'(ovp_fault), 32'h1, "fault after deglitch");
    rd(STAT_OFS, 32'h11, 32'h11, RESP_OKAY);
    set_cell(13'd3720);
    repeat (5) @(posedge aclk);
    cmp(32'(ovp_fault), 32'h1, "fault held above recharge");
    wr(CTRL_OFS, 32'h3, RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp(32'(ovp_fault), 32'h0, "fault cleared by high impedance");
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    set_cell(13'd3950);
    repeat (40030) @(posedge aclk);
    cmp(32'(ovp_fault), 32'h1, "fault raised again");
    set_cell(13'd3500);
    repeat (5) @(posedge aclk);
    cmp(32'(ovp_fault), 32'h0, "fault cleared below recharge");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
